// ---- src/lut_ram_cfg.svh ----
// Constants for the lookup-table memory: sizes, mode codes and default contents.
`ifndef LUT_RAM_CFG_SVH
`define LUT_RAM_CFG_SVH

// Words in one half and width of its address.
`define LUT_HALF_DEPTH 16
`define LUT_ADDR_W     4
// Words in the joined single-port arrangement.
`define LUT_FULL_DEPTH 32
// Contents loaded at configuration when no others are given.
`define LUT_INIT_ZERO  32'h0000_0000
// Arrangement codes; Gray order from dual-port through to level mode.
`define LUT_MODE_DUAL  2'h0
`define LUT_MODE_E16X2 2'h1
`define LUT_MODE_E32X1 2'h3
`define LUT_MODE_LEVEL 2'h2
// Upper half starts at this bit of the store.
`define LUT_HALF_B_LSB 16

`endif

// ---- src/lut_ram_pkg.sv ----
// Types shared by the lookup-table memory and its write-capture stage.
`default_nettype none

package lut_ram_pkg;
`include "lut_ram_cfg.svh"

   // Arrangement of the two halves and their write timing.
   typedef enum logic [1:0] {
      MODE_DUAL  = `LUT_MODE_DUAL,
      MODE_E16X2 = `LUT_MODE_E16X2,
      MODE_E32X1 = `LUT_MODE_E32X1,
      MODE_LEVEL = `LUT_MODE_LEVEL
   } ram_mode_e;

   typedef logic [`LUT_ADDR_W-1:0] half_addr_t;

endpackage : lut_ram_pkg

`default_nettype wire

// ---- src/lut_write_capture.sv ----
// Write-clock edge detection and capture of address, data and strobe.
`default_nettype none

module lut_write_capture
   import lut_ram_pkg::*;
(
   // Clock and synchronised reset.
   input  wire logic              clk_sys,
   input  wire logic              rst_sync_n,
   // Write clock as sampled fabric signal, and its active-edge choice.
   input  wire logic              write_clk,
   input  wire logic              edge_falling,
   // Fabric write request.
   input  wire lut_ram_pkg::half_addr_t addr,
   input  wire logic              addr_hi,
   input  wire logic              data_a,
   input  wire logic              data_b,
   input  wire logic              write_strobe,
   // Captured request and the internal write pulse.
   output logic                   wr_pulse,
   output lut_ram_pkg::half_addr_t wr_addr,
   output logic                   wr_addr_hi,
   output logic                   wr_data_a,
   output logic                   wr_data_b
);
   import lut_ram_pkg::*;

   typedef struct packed {
      logic       clk_prev;
      logic       pulse;
      half_addr_t addr;
      logic       addr_hi;
      logic       data_a;
      logic       data_b;
   } cap_s;

   cap_s st_q;
   cap_s st_d;
   logic active_edge;

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection: the chosen sense of the write clock marks the edge.
   always_comb
   begin
      active_edge = edge_falling ? (st_q.clk_prev & ~write_clk)
                                 : (~st_q.clk_prev & write_clk);
      st_d          = st_q;
      st_d.clk_prev = write_clk;
      st_d.pulse    = 1'b0;
      // Address, data and strobe are all taken on the edge; the store is
      // written one cycle later, so a late change cannot disturb it.
      if (active_edge)
      begin
         st_d.addr    = addr;
         st_d.addr_hi = addr_hi;
         st_d.data_a  = data_a;
         st_d.data_b  = data_b;
         st_d.pulse   = write_strobe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign wr_pulse   = st_q.pulse;
   assign wr_addr    = st_q.addr;
   assign wr_addr_hi = st_q.addr_hi;
   assign wr_data_a  = st_q.data_a;
   assign wr_data_b  = st_q.data_b;

endmodule : lut_write_capture

`default_nettype wire

// ---- src/lut_dual_port_ram.sv ----
// Lookup-table memory: dual-port, edge-triggered and level-sensitive modes.
`default_nettype none

`include "lut_ram_cfg.svh"

// What this block does
// - Both halves form one 16x1 dual-port memory.
// - Read and write together, same address allowed.
// - Dual-port writes only on the write edge.
// - Shared address writes and drives primary read.
// - Secondary read uses the second read address; 32x1 uses the shared address.
// - Second half written at shared address; level mode uses second read address.
// - One data bit written into both halves in dual-port mode.
// - Level mode writes like a latch.
// - Configuration loads given contents, else zeros.
// - Reset never changes stored contents.
// - Edge captures address, data, strobe; then writes.
// - Edge sense selectable; strobe active high.
// - 32x1: second data input is fifth address bit.
module lut_dual_port_ram
   import lut_ram_pkg::*;
#(
   parameter logic [`LUT_FULL_DEPTH-1:0] INIT_CONTENTS = `LUT_INIT_ZERO
)
(
   // Clock and reset.
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   // Static arrangement chosen with the cell's configuration.
   input  wire lut_ram_pkg::ram_mode_e  mode,
   input  wire logic                    edge_falling,
   // Write side from fabric logic.
   input  wire logic                    write_clk,
   input  wire logic                    write_strobe,
   input  wire lut_ram_pkg::half_addr_t addr,
   input  wire logic                    first_data_input,
   input  wire logic                    second_data_input,
   // Second read port.
   input  wire lut_ram_pkg::half_addr_t second_read_address,
   // Read results and write completion.
   output logic                         primary_read_out,
   output logic                         secondary_read_out,
   output logic                         write_done
);
   import lut_ram_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Types and signals.

   typedef struct packed {
      logic rst_meta;
      logic rst_sync;
   } rst_s;

   typedef struct packed {
      logic pri;
      logic sec;
      logic done;
   } out_s;

   rst_s                       rs_q;
   out_s                       st_q;
   out_s                       st_d;
   logic                       rst_sync_n;

   // Store: bits 15..0 are the first half, bits 31..16 the second.
   // In the 32x1 arrangement the fifth address bit picks between them.
   logic [`LUT_FULL_DEPTH-1:0] mem_q = INIT_CONTENTS;
   logic [`LUT_FULL_DEPTH-1:0] mem_d;
   logic                       mem_we;

   logic                       cap_pulse;
   half_addr_t                 cap_addr;
   logic                       cap_addr_hi;
   logic                       cap_data_a;
   logic                       cap_data_b;

   logic                       edge_mode;
   logic                       level_write;

   // Write steering: word and bit chosen for each half, and whether to write.
   half_addr_t                 lo_addr;
   logic                       lo_data;
   logic                       lo_en;
   half_addr_t                 hi_addr;
   logic                       hi_data;
   logic                       hi_en;

   // Read steering: half and word chosen for each read port.
   logic                       pri_hi;
   half_addr_t                 pri_addr;
   logic                       sec_hi;
   half_addr_t                 sec_addr;

   ////////////////////////////////////////////////////////////////////////////
   // Functions.

   // Bit index in the store of a word in the chosen half.
   function automatic logic [4:0] half_index(input logic hi, input half_addr_t a);
      half_index = {hi, a};
   endfunction : half_index

   // Read one bit of the store.
   function automatic logic read_bit(input logic [`LUT_FULL_DEPTH-1:0] m,
                                     input logic hi, input half_addr_t a);
      read_bit = m[half_index(hi, a)];
   endfunction : read_bit

   // Return the store with one bit replaced.
   function automatic logic [`LUT_FULL_DEPTH-1:0] put_bit(
      input logic [`LUT_FULL_DEPTH-1:0] m, input logic hi,
      input half_addr_t a, input logic v);
      logic [`LUT_FULL_DEPTH-1:0] r;
      r = m;
      r[half_index(hi, a)] = v;
      put_bit = r;
   endfunction : put_bit

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops; assertion is immediate.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rs_q <= '0;
      else
         rs_q <= '{rst_meta: 1'b1, rst_sync: rs_q.rst_meta};
   end

   assign rst_sync_n = rs_q.rst_sync;

   ////////////////////////////////////////////////////////////////////////////
   // Edge-triggered write capture, shared by every edge mode.
   lut_write_capture u_capture (
      .clk_sys      (clk_sys),
      .rst_sync_n   (rst_sync_n),
      .write_clk    (write_clk),
      .edge_falling (edge_falling),
      .addr         (addr),
      .addr_hi      (second_data_input),
      .data_a       (first_data_input),
      .data_b       (second_data_input),
      .write_strobe (write_strobe),
      .wr_pulse     (cap_pulse),
      .wr_addr      (cap_addr),
      .wr_addr_hi   (cap_addr_hi),
      .wr_data_a    (cap_data_a),
      .wr_data_b    (cap_data_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Write steering. Each arrangement names, for each half, the word to
   // write and the bit to put there. Dual-port mode has no level path at
   // all, so a strobe held high without a write-clock edge never touches
   // the store there.
   always_comb
   begin
      edge_mode   = (mode != MODE_LEVEL);
      level_write = (mode == MODE_LEVEL) && write_strobe;
      lo_addr     = cap_addr;
      lo_data     = cap_data_a;
      lo_en       = 1'b0;
      hi_addr     = cap_addr;
      hi_data     = cap_data_a;
      hi_en       = 1'b0;
      if (edge_mode && cap_pulse)
      begin
         case (mode)
            MODE_DUAL:
            begin
               // One bit at the shared address lands in both halves, so the
               // second read port always sees the same contents.
               lo_en = 1'b1;
               hi_en = 1'b1;
            end
            MODE_E16X2:
            begin
               hi_data = cap_data_b;
               lo_en   = 1'b1;
               hi_en   = 1'b1;
            end
            MODE_E32X1:
            begin
               // The fifth address bit picks one half; the other is untouched.
               lo_en = ~cap_addr_hi;
               hi_en = cap_addr_hi;
            end
            default:
            begin
               lo_en = 1'b0;
               hi_en = 1'b0;
            end
         endcase
      end
      else if (level_write)
      begin
         // Latch behaviour: every cycle with the strobe high rewrites the
         // word now addressed with the data now presented. Nothing guards
         // against an address that moves under a high strobe; keeping it
         // steady is the duty of the driving logic.
         lo_addr = addr;
         lo_data = first_data_input;
         hi_addr = second_read_address;
         hi_data = second_data_input;
         lo_en   = 1'b1;
         hi_en   = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Store update: only the bits chosen above change. Both halves are
   // written in one cycle, so they never disagree in between.
   always_comb
   begin
      mem_we = lo_en | hi_en;
      mem_d  = mem_q;
      if (lo_en)
         mem_d = put_bit(mem_d, 1'b0, lo_addr, lo_data);
      if (hi_en)
         mem_d = put_bit(mem_d, 1'b1, hi_addr, hi_data);
   end

   ////////////////////////////////////////////////////////////////////////////
   // The store has no reset: contents come only from configuration, and
   // the chip-wide reset leaves them alone.
   always_ff @(posedge clk_sys)
   begin
      if (mem_we)
         mem_q <= mem_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read steering. Each port picks a half and a word. Only the joined 32x1
   // arrangement lets a data pin choose the half, and there both ports look
   // at the same word; every other arrangement reads the lower half through
   // the shared address and the upper half through the second read address.
   always_comb
   begin
      pri_hi   = 1'b0;
      pri_addr = addr;
      sec_hi   = 1'b1;
      sec_addr = second_read_address;
      case (mode)
         MODE_E32X1:
         begin
            pri_hi   = second_data_input;
            sec_hi   = second_data_input;
            sec_addr = addr;
         end
         MODE_DUAL,
         MODE_E16X2,
         MODE_LEVEL:
         begin
            pri_hi = 1'b0;
            sec_hi = 1'b1;
         end
         default:
         begin
            pri_hi = 1'b0;
            sec_hi = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read ports. Both are looked up every clk_sys cycle from the store as it
   // stands after any write of this cycle, so a read of the address being
   // written returns the new bit; the write clock plays no part. The price
   // of registered outputs is one cycle of read latency.
   always_comb
   begin
      st_d      = st_q;
      st_d.done = mem_we && edge_mode;
      st_d.pri  = read_bit(mem_d, pri_hi, pri_addr);
      st_d.sec  = read_bit(mem_d, sec_hi, sec_addr);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output register. Only the outputs are cleared by reset; the store
   // behind them keeps its contents.
   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign primary_read_out   = st_q.pri;
   assign secondary_read_out = st_q.sec;
   assign write_done         = st_q.done;

endmodule : lut_dual_port_ram

`default_nettype wire

// ---- bench/lut_ram_props.sv ----
// Port checker for the lookup-table memory.
`default_nettype none
module lut_ram_props
(
   // Clock and reset.
   input wire logic                    clk_sys,
   input wire logic                    rst_n,
   // Watched ports.
   input wire lut_ram_pkg::ram_mode_e  mode,
   input wire logic                    edge_falling,
   input wire logic                    write_clk,
   input wire logic                    write_strobe,
   input wire lut_ram_pkg::half_addr_t addr,
   input wire logic                    first_data_input,
   input wire lut_ram_pkg::half_addr_t second_read_address,
   input wire logic                    primary_read_out,
   input wire logic                    secondary_read_out,
   input wire logic                    write_done
);
   timeunit 1ns;
   timeprecision 1ps;
   import lut_ram_pkg::*;
   logic wc_q;
   logic act;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Previous write-clock sample; the edge shows between two samples.
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
         wc_q <= 1'b0;
      else
         wc_q <= write_clk;
   // Active write edge in the chosen sense.
   assign act = edge_falling ? (wc_q & ~write_clk) : (~wc_q & write_clk);
   sequence s_wr;
      act && write_strobe && mode == MODE_DUAL;
   endsequence
   sequence s_hold;
      addr == $past(addr) && second_read_address == $past(addr);
   endsequence
   a_done_edge: assert property (
      act && write_strobe && mode != MODE_LEVEL |-> ##2 write_done)
      else $error("no write_done after strobed edge");
   a_refuse_low: assert property (
      act && !write_strobe |-> ##2 !write_done)
      else $error("write_done without strobe");
   a_done_cause: assert property (
      write_done |-> $past(act, 2) && $past(write_strobe, 2))
      else $error("write_done without active edge");
   a_level_nodone: assert property (
      mode == MODE_LEVEL |-> !write_done)
      else $error("write_done in level mode");
   a_done_pulse: assert property (
      write_done |=> !write_done)
      else $error("write_done longer than one cycle");
   a_same_addr: assert property (
      s_wr ##1 s_hold |-> ##1 primary_read_out == $past(first_data_input, 2)
         && secondary_read_out == $past(first_data_input, 2))
      else $error("same-address read missed new bit");
   a_halves_equal: assert property (
      mode == MODE_DUAL && addr == second_read_address
         |=> primary_read_out == secondary_read_out)
      else $error("halves differ");
   a_level_write: assert property (
      mode == MODE_LEVEL && write_strobe |=> primary_read_out == $past(first_data_input))
      else $error("level write not seen");
endmodule : lut_ram_props

bind lut_dual_port_ram lut_ram_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
   .mode(mode), .edge_falling(edge_falling), .write_clk(write_clk),
   .write_strobe(write_strobe), .addr(addr), .first_data_input(first_data_input),
   .second_read_address(second_read_address), .primary_read_out(primary_read_out),
   .secondary_read_out(secondary_read_out), .write_done(write_done));
`default_nettype wire

// ---- bench/fabric_logic.sv ----
// Model of the fabric user logic driving the memory's write side.
`default_nettype none
module fabric_logic
(
   // Clock and write-clock sense.
   input  wire logic                    clk_sys,
   input  wire logic                    edge_falling,
   // Write side.
   output var logic                     write_clk,
   output var logic                     write_strobe,
   output var lut_ram_pkg::half_addr_t  addr,
   output var logic                     first_data_input,
   output var logic                     second_data_input
);
   timeunit 1ns;
   timeprecision 1ps;
   import lut_ram_pkg::*;
   // Idle: clock low so no edge is seen at reset release.
   initial
   begin
      write_clk = 1'b0;
      write_strobe = 1'b0;
      addr = 4'h0;
      first_data_input = 1'b0;
      second_data_input = 1'b1;
   end
   // Moves the shared address only.
   task automatic point(input half_addr_t a);
      addr <= a;
   endtask : point
   // Both data pins carry one bit, so the halves never diverge.
   task automatic put(input logic d);
      first_data_input <= d;
      second_data_input <= d;
   endtask : put
   // Edge write; released data turns over so a late capture shows.
   task automatic ew(input half_addr_t a, input logic d, input logic s);
      @(negedge clk_sys);
      addr <= a;
      put(d);
      write_strobe <= s;
      @(negedge clk_sys);
      write_clk <= 1'b1;
      @(negedge clk_sys);
      write_clk <= 1'b0;
      if (edge_falling)
         @(negedge clk_sys);
      write_strobe <= 1'b0;
      put(~d);
   endtask : ew
   // Rising-edge write with the two data pins apart; the pins keep their
   // values afterwards, since in 32x1 the second one also steers reads.
   task automatic ew2(input half_addr_t a, input logic d0, input logic d1);
      @(negedge clk_sys);
      addr <= a;
      first_data_input <= d0;
      second_data_input <= d1;
      write_strobe <= 1'b1;
      @(negedge clk_sys);
      write_clk <= 1'b1;
      @(negedge clk_sys);
      write_clk <= 1'b0;
      write_strobe <= 1'b0;
   endtask : ew2
   // Strobe pulse with settled address; data turns mid-pulse.
   task automatic lw(input half_addr_t a, input logic d);
      @(negedge clk_sys);
      addr <= a;
      put(~d);
      @(negedge clk_sys);
      write_strobe <= 1'b1;
      @(negedge clk_sys);
      put(d);
      @(negedge clk_sys);
      write_strobe <= 1'b0;
      @(negedge clk_sys);
      put(~d);
   endtask : lw
endmodule : fabric_logic
`default_nettype wire

// ---- bench/test_lut_dual_port_ram.sv ----
// Self-checking bench for the lookup-table memory.
`default_nettype none
module test_lut_dual_port_ram;
   timeunit 1ns;
   timeprecision 1ps;
   import lut_ram_pkg::*;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   ram_mode_e  mode = MODE_DUAL;
   logic       edge_falling = 1'b0;
   half_addr_t second_read_address = 4'h0;
   half_addr_t addr;
   logic       write_clk;
   logic       write_strobe;
   logic       first_data_input;
   logic       second_data_input;
   logic       primary_read_out;
   logic       secondary_read_out;
   logic       write_done;
   logic       mem [16] = '{default: 1'b0};
   int         err_total = 0;
   int         checked = 0;
   // 125 MHz clock.
   always #4 clk_sys = ~clk_sys;
   lut_dual_port_ram dut (.clk_sys(clk_sys), .rst_n(rst_n), .mode(mode),
      .edge_falling(edge_falling), .write_clk(write_clk), .write_strobe(write_strobe),
      .addr(addr), .first_data_input(first_data_input),
      .second_data_input(second_data_input), .second_read_address(second_read_address),
      .primary_read_out(primary_read_out), .secondary_read_out(secondary_read_out),
      .write_done(write_done));
   fabric_logic fab (.clk_sys(clk_sys), .edge_falling(edge_falling),
      .write_clk(write_clk), .write_strobe(write_strobe), .addr(addr),
      .first_data_input(first_data_input), .second_data_input(second_data_input));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp)
      begin
         $display("BAD %s expected %b seen %b", what, exp, got);
         err_total++;
      end
   endtask : chk
   // Reads take one clock, so results are looked at a full cycle later.
   task automatic rd(input half_addr_t a, input half_addr_t b);
      @(negedge clk_sys);
      fab.point(a);
      second_read_address <= b;
      @(negedge clk_sys);
      chk("primary_read_out", mem[a], primary_read_out);
      chk("secondary_read_out", mem[b], secondary_read_out);
   endtask : rd
   task automatic wr(input half_addr_t a, input logic d, input logic s);
      logic seen;
      seen = 1'b0;
      fab.ew(a, d, s);
      if (s)
         mem[a] = d;
      repeat (4)
      begin
         @(negedge clk_sys);
         seen |= (write_done === 1'b1);
      end
      chk("write_done", s, seen);
   endtask : wr
   // Crossed addresses so the two ports never read the same word.
   task automatic vfy();
      for (int i = 0; i < 16; i++)
         rd(4'(i), 4'(15 - i));
   endtask : vfy
   task automatic t_main();
      vfy();
      for (int i = 0; i < 16; i++)
         wr(4'(i), 1'(i ^ (i >> 2) ^ (i >> 3)), 1'b1);
      vfy();
      rd(4'h6, 4'h6);
      wr(4'h6, ~mem[6], 1'b1);
      rd(4'h6, 4'h6);
      wr(4'h2, ~mem[2], 1'b0);
      fab.lw(4'h3, ~mem[3]);
      rd(4'h2, 4'h3);
      $display("dual-port tests done");
   endtask : t_main
   task automatic t_modes();
      @(negedge clk_sys);
      edge_falling <= 1'b1;
      wr(4'h9, ~mem[9], 1'b1);
      rd(4'h9, 4'h9);
      edge_falling <= 1'b0;
      second_read_address <= 4'h4;
      mode <= MODE_LEVEL;
      fab.lw(4'h4, ~mem[4]);
      mem[4] = ~mem[4];
      rd(4'h4, 4'h4);
      mode <= MODE_DUAL;
      $display("edge sense and level tests done");
   endtask : t_modes
   // Split arrangements: halves apart in 16x2, a fifth address bit in 32x1.
   task automatic t_split();
      logic v;
      v = mem[10];
      @(negedge clk_sys);
      mode <= MODE_E16X2;
      second_read_address <= 4'ha;
      fab.ew2(4'ha, ~v, v);
      @(negedge clk_sys);
      chk("primary_read_out", ~v, primary_read_out);
      chk("secondary_read_out", v, secondary_read_out);
      mode <= MODE_E32X1;
      fab.ew2(4'ha, v, 1'b0);
      @(negedge clk_sys);
      chk("primary_read_out", v, primary_read_out);
      chk("secondary_read_out", v, secondary_read_out);
      fab.ew2(4'ha, ~v, 1'b1);
      @(negedge clk_sys);
      chk("primary_read_out", ~v, primary_read_out);
      fab.put(1'b0);
      @(negedge clk_sys);
      chk("primary_read_out", v, primary_read_out);
      fab.ew2(4'ha, v, 1'b1);
      @(negedge clk_sys);
      mode <= MODE_DUAL;
      $display("split arrangement tests done");
   endtask : t_split
   // Contents have no reset path, so they must outlive a reset pulse.
   task automatic t_reset();
      @(negedge clk_sys);
      rst_n <= 1'b0;
      repeat (3) @(negedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(negedge clk_sys);
      vfy();
      $display("reset test done");
   endtask : t_reset
   task automatic test_done();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // Main sequence after a 12-cycle reset.
   initial
   begin
      repeat (12) @(negedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(negedge clk_sys);
      t_main();
      t_modes();
      t_split();
      t_reset();
      test_done();
   end
   // The run needs some 300 cycles; over fifteen times that means a hang.
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      err_total++;
      test_done();
   end
endmodule : test_lut_dual_port_ram
`default_nettype wire
